// >>> cmpo_pkg.sv
// Register map, field layout and timing constants of the comparator control block
package cmpo_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_STATUS_CONTROL = 10'h02f;
  localparam logic [9:0] IDX_AUX_CONTROL    = 10'h03a;
  localparam logic [9:0] IDX_ADC_CONTROL_B  = 10'h07b;

  localparam logic [7:0] RST_STATUS_CONTROL = 8'h80;
  localparam logic [7:0] RST_AUX_CONTROL    = 8'h00;
  localparam logic [7:0] RST_ADC_CONTROL_B  = 8'h00;

  // Status/control fields
  localparam int SC_DISABLE     = 7;
  localparam int SC_POS_BANK    = 6;
  localparam int SC_RESULT      = 5;
  localparam int SC_EVENT_FLAG  = 4;
  localparam int SC_IRQ_ENABLE  = 3;
  localparam int SC_CAPTURE_SEL = 2;
  localparam int SC_MODE_HI     = 1;
  localparam int SC_MODE_LO     = 0;

  // Auxiliary control fields; bit 7 is reserved and reads zero
  localparam int AX_PIN_OUT_EN  = 6;
  localparam int AX_HYST_EN     = 5;
  localparam int AX_POS_LOW     = 4;
  localparam int AX_WAKE_EN     = 3;
  localparam int AX_FILTER_EN   = 2;
  localparam int AX_WIDTH_HI    = 1;
  localparam int AX_WIDTH_LO    = 0;
  localparam logic [7:0] AX_WRITE_MASK = 8'h7f;

  // ADC control B fields
  localparam int AB_NEG_HIGH    = 5;
  localparam int AB_NEG_LOW     = 4;
  localparam int AB_TRIG_SEL    = 3;

  // Trigger modes
  localparam logic [1:0] MODE_BOTH     = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALL     = 2'h2;
  localparam logic [1:0] MODE_RISE     = 2'h3;

  // Filter step: one width code unit is 32 us at a 125 MHz clock
  localparam int CLK_MHZ        = 125;
  localparam int FILT_STEP_US   = 32;
  localparam int FILT_STEP_CYC  = FILT_STEP_US * CLK_MHZ;
  localparam int FILT_CNT_W     = 16;

endpackage

// >>> cmpo_level_if.sv
// Carries the filtered comparator level from the filter to the edge detector
`timescale 1ns/1ns
interface cmpo_level_if;
  logic level;
  modport src (output level);
  modport snk (input level);
endinterface

// >>> cmpo_filter.sv
// Digital stability filter on the synchronised comparator output
`timescale 1ns/1ns
module cmpo_filter
  import cmpo_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = FILT_STEP_CYC
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       raw,
  input  wire logic       enable,
  input  wire logic [1:0] width,
  cmpo_level_if.src       out
);

  // The widest window must still fit the counter
  if (STEP_CYCLES < 1 || STEP_CYCLES * 3 >= (1 << FILT_CNT_W)) begin : g_bad_step
    $error("cmpo_filter: STEP_CYCLES out of range");
  end

  logic [FILT_CNT_W-1:0] count;
  logic [FILT_CNT_W-1:0] limit;
  logic                  bypass;

  always_comb begin
    limit = FILT_CNT_W'(STEP_CYCLES * width);
  end
  assign bypass = !enable || (width == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count     <= '0;
      out.level <= 1'b0;
    end else if (bypass || raw == out.level) begin
      count     <= '0;
      out.level <= raw;
    end else if (count + 1'b1 >= limit) begin
      // Raw held its new level for the whole width
      count     <= '0;
      out.level <= raw;
    end else begin
      count <= count + 1'b1;
    end
  end

endmodule

// >>> cmpo_edge.sv
// Edge detector that raises the trigger-mode event and any-edge activity pulses
`timescale 1ns/1ns
module cmpo_edge
  import cmpo_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  cmpo_level_if.snk       in,
  input  wire logic [1:0] mode,
  output logic            event_pulse,
  output logic            activity
);

  logic prev;
  logic rise;
  logic fall;

  assign rise = in.level && !prev;
  assign fall = !in.level && prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 1'b0;
    end else begin
      prev <= in.level;
    end
  end

  always_comb begin
    case (mode)
      MODE_BOTH:     event_pulse = rise || fall;
      MODE_FALL:     event_pulse = fall;
      MODE_RISE:     event_pulse = rise;
      MODE_RESERVED: event_pulse = 1'b0;
      default:       event_pulse = 1'b0;
    endcase
  end

  assign activity = rise || fall;

endmodule

// >>> cmpo_control.sv
// Register file and control logic of the second analog comparator
`timescale 1ns/1ns

module cmpo_control
  import cmpo_pkg::*;
#(
  parameter int unsigned FILTER_STEP_CYCLES = FILT_STEP_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmp_raw,
  input  wire logic        cmp0_result,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_ack,
  output logic             irq,
  output logic             wake_req,
  output logic             adc_trigger,
  output logic             cmp_power_down,
  output logic             cmp_hyst_enable,
  output logic             cmp_pin_out_enable,
  output logic             cmp_pin_out,
  output logic             cmp_capture_select,
  output logic             pos_connect,
  output logic       [1:0] pos_select,
  output logic       [1:0] neg_select,
  output logic       [1:0] adc_trigger_source,
  output logic       [2:0] adc_auto_source
);

  // Register index decode, used by both read and write paths
  function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
    reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // Two-flop synchronisers for the asynchronous comparator outputs
  logic [1:0] sync_in;
  logic [1:0] sync_s1;
  logic [1:0] sync_s2;

  assign sync_in = {cmp0_result, cmp_raw};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_s1[gi] <= 1'b0;
          sync_s2[gi] <= 1'b0;
        end else begin
          sync_s1[gi] <= sync_in[gi];
          sync_s2[gi] <= sync_s1[gi];
        end
      end
    end
  endgenerate

  // Register storage; the status register is kept field by field
  logic [7:0] status_control;
  logic [7:0] aux_control;
  logic [7:0] adc_control_b;
  logic       sc_disable;
  logic       sc_pos_bank;
  logic       sc_result;
  logic       sc_event_flag;
  logic       sc_irq_enable;
  logic       sc_capture_sel;
  logic [1:0] sc_mode;
  logic       sc_write;

  // Bus access qualifiers; the write lands on the edge that samples pready high
  logic access_done;
  logic wr_en;
  logic hit_sc;
  logic hit_ax;
  logic hit_ab;
  logic hit_any;

  assign access_done = psel && penable && pready;
  assign wr_en       = access_done && pwrite;
  assign hit_sc      = reg_hit(paddr, IDX_STATUS_CONTROL);
  assign hit_ax      = reg_hit(paddr, IDX_AUX_CONTROL);
  assign hit_ab      = reg_hit(paddr, IDX_ADC_CONTROL_B);
  assign hit_any     = hit_sc || hit_ax || hit_ab;

  // Filter and edge detection
  cmpo_level_if filt_level ();

  logic raw_gated;
  logic cmp_event;
  logic cmp_activity;

  // A powered-down comparator presents a steady low output
  assign raw_gated = sync_s2[0] && !status_control[SC_DISABLE];

  cmpo_filter #(
    .STEP_CYCLES (FILTER_STEP_CYCLES)
  ) u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (raw_gated),
    .enable  (aux_control[AX_FILTER_EN]),
    .width   (aux_control[AX_WIDTH_HI:AX_WIDTH_LO]),
    .out     (filt_level)
  );

  cmpo_edge u_edge (
    .pclk        (pclk),
    .presetn     (presetn),
    .in          (filt_level),
    .mode        (status_control[SC_MODE_HI:SC_MODE_LO]),
    .event_pulse (cmp_event),
    .activity    (cmp_activity)
  );

  // Status/control register: software fields, live result and sticky flag
  always_comb begin
    status_control                        = 8'h00;
    status_control[SC_DISABLE]            = sc_disable;
    status_control[SC_POS_BANK]           = sc_pos_bank;
    status_control[SC_RESULT]             = sc_result;
    status_control[SC_EVENT_FLAG]         = sc_event_flag;
    status_control[SC_IRQ_ENABLE]         = sc_irq_enable;
    status_control[SC_CAPTURE_SEL]        = sc_capture_sel;
    status_control[SC_MODE_HI:SC_MODE_LO] = sc_mode;
  end

  assign sc_write = wr_en && hit_sc;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_disable <= RST_STATUS_CONTROL[SC_DISABLE];
    end else if (sc_write) begin
      sc_disable <= pwdata[SC_DISABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_pos_bank <= RST_STATUS_CONTROL[SC_POS_BANK];
    end else if (sc_write) begin
      sc_pos_bank <= pwdata[SC_POS_BANK];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_irq_enable <= RST_STATUS_CONTROL[SC_IRQ_ENABLE];
    end else if (sc_write) begin
      sc_irq_enable <= pwdata[SC_IRQ_ENABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_capture_sel <= RST_STATUS_CONTROL[SC_CAPTURE_SEL];
    end else if (sc_write) begin
      sc_capture_sel <= pwdata[SC_CAPTURE_SEL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_mode <= RST_STATUS_CONTROL[SC_MODE_HI:SC_MODE_LO];
    end else if (sc_write) begin
      sc_mode <= pwdata[SC_MODE_HI:SC_MODE_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_result <= RST_STATUS_CONTROL[SC_RESULT];
    end else begin
      sc_result <= filt_level.level;
    end
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_event_flag <= RST_STATUS_CONTROL[SC_EVENT_FLAG];
    end else if (cmp_event) begin
      sc_event_flag <= 1'b1;
    end else if ((sc_write && pwdata[SC_EVENT_FLAG]) || irq_ack) begin
      sc_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_control <= RST_AUX_CONTROL;
    end else if (wr_en && hit_ax) begin
      aux_control <= pwdata[7:0] & AX_WRITE_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_control_b <= RST_ADC_CONTROL_B;
    end else if (wr_en && hit_ab) begin
      adc_control_b <= pwdata[7:0];
    end
  end

  // APB slave: no wait states, ready and read data registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= !hit_any;
      if (pwrite || !hit_any) begin
        prdata <= 32'h0000_0000;
      end else if (hit_sc) begin
        prdata <= {24'h00_0000, status_control};
      end else if (hit_ax) begin
        prdata <= {24'h00_0000, aux_control};
      end else begin
        prdata <= {24'h00_0000, adc_control_b};
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Interrupt request, held as a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= status_control[SC_EVENT_FLAG] && status_control[SC_IRQ_ENABLE]
             && global_irq_enable;
    end
  end

  // Wake request pulses on any filtered output transition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= cmp_activity && aux_control[AX_WAKE_EN];
    end
  end

  // ADC auto-conversion trigger source; first comparator is taken as a level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_trigger <= 1'b0;
    end else if (adc_control_b[AB_TRIG_SEL]) begin
      adc_trigger <= filt_level.level;
    end else begin
      adc_trigger <= sync_s2[1];
    end
  end

  // Analog steering outputs, registered for glitch-free switching
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_power_down <= RST_STATUS_CONTROL[SC_DISABLE];
    end else begin
      cmp_power_down <= status_control[SC_DISABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_hyst_enable <= 1'b0;
    end else begin
      cmp_hyst_enable <= aux_control[AX_HYST_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_pin_out_enable <= 1'b0;
    end else begin
      cmp_pin_out_enable <= aux_control[AX_PIN_OUT_EN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_pin_out <= 1'b0;
    end else begin
      cmp_pin_out <= filt_level.level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_capture_select <= 1'b0;
    end else begin
      cmp_capture_select <= status_control[SC_CAPTURE_SEL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_select <= 2'h0;
    end else begin
      pos_select <= {status_control[SC_POS_BANK], aux_control[AX_POS_LOW]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_connect <= 1'b1;
    end else begin
      pos_connect <= !(status_control[SC_POS_BANK] && aux_control[AX_POS_LOW]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_select <= 2'h0;
    end else begin
      neg_select <= adc_control_b[AB_NEG_HIGH:AB_NEG_LOW];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_trigger_source <= 2'h0;
    end else begin
      adc_trigger_source <= adc_control_b[7:6];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_auto_source <= 3'h0;
    end else begin
      adc_auto_source <= adc_control_b[2:0];
    end
  end

endmodule

// >>> cmpo_control_sva.sv
// Port-level assertions for the comparator control block
`timescale 1ns/1ns
module cmpo_control_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        global_irq_enable,
  input wire logic        irq,
  input wire logic        cmp_power_down,
  input wire logic        pos_connect,
  input wire logic [1:0]  pos_select,
  input wire logic [1:0]  neg_select
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence

  chk_ready_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_read: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  // Register lands on the access edge, the steering output one edge later
  chk_neg_write: assert property (s_wr(12'h1ec) |-> ##2
    neg_select == $past(pwdata[5:4], 2))
    else $error("negative select not loaded");
  chk_neg_hold: assert property (!(psel && penable && pwrite) |=> ##1
    $stable(neg_select))
    else $error("negative select moved");
  chk_power_write: assert property (s_wr(12'h0bc) |-> ##2
    cmp_power_down == $past(pwdata[7], 2))
    else $error("power down not loaded");
  chk_pos_off: assert property (pos_connect == (pos_select != 2'b11))
    else $error("positive connect wrong");
  chk_irq_gate: assert property (!global_irq_enable |=> !irq)
    else $error("irq while globally off");
endmodule

// >>> testbench.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ns
module testbench;
  import cmpo_pkg::*;
  // Short filter step keeps the widest window at 12 cycles
  localparam int STEP = 4;
  localparam logic [11:0] A_SC = {IDX_STATUS_CONTROL, 2'b00};
  localparam logic [11:0] A_AX = {IDX_AUX_CONTROL, 2'b00};
  localparam logic [11:0] A_AB = {IDX_ADC_CONTROL_B, 2'b00};
  logic        pclk, presetn, psel, penable, pwrite, cmp_raw, cmp0_result;
  logic        global_irq_enable, irq_ack, pready, pslverr, irq, wake_req;
  logic        adc_trigger, cmp_power_down, cmp_hyst_enable, cmp_pin_out_enable;
  logic        cmp_pin_out, cmp_capture_select, pos_connect;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [1:0]  pos_select, neg_select, adc_trigger_source, m;
  logic [2:0]  adc_auto_source;
  logic [32:0] expq[$];
  logic [1:0]  modes[4] = '{MODE_FALL, MODE_RISE, MODE_RESERVED, MODE_BOTH};
  int          bad_count, checked, wk;

  cmpo_control #(.FILTER_STEP_CYCLES(STEP)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_raw, .cmp0_result,
    .global_irq_enable, .irq_ack, .irq, .wake_req, .adc_trigger, .cmp_power_down,
    .cmp_hyst_enable, .cmp_pin_out_enable, .cmp_pin_out, .cmp_capture_select,
    .pos_connect, .pos_select, .neg_select, .adc_trigger_source, .adc_auto_source);

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One edge of idle follows each transfer so psel is never set twice in a step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic e, input logic [7:0] d);
    expq.push_back({e, 24'h00_0000, d});
    apb(0, a, 8'h00);
  endtask

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expq.size() == 0) check(33'h0, 33'h1);
      else check({pslverr, prdata}, expq.pop_front());
    end
    if (wake_req === 1'b1) wk++;
  end

  initial begin
    pclk = 0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, cmp_raw, cmp0_result, global_irq_enable, irq_ack} = '0;
    paddr = '0;
    pwdata = '0;
    void'($urandom(32'h8b40));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(A_SC, 0, 8'h80);
    check(cmp_power_down, 1);
    rd(A_AX, 0, 8'h00);
    rd(A_AB, 0, 8'h00);
    rd(12'h004, 1, 8'h00);
    // Misaligned alias of the aux register must be refused
    apb(1, 12'h0e9, 8'hff);
    rd(A_AX, 0, 8'h00);
    r = $urandom;
    apb(1, A_AX, r[7:0]);
    rd(A_AX, 0, r[7:0] & 8'h7f);
    check(cmp_hyst_enable, r[5]);
    check(cmp_pin_out_enable, r[6]);
    apb(1, A_AB, r[15:8]);
    rd(A_AB, 0, r[15:8]);
    check({adc_trigger_source, neg_select, adc_auto_source}, {r[15:12], r[10:8]});
    for (int c = 0; c < 4; c++) begin
      apb(1, A_SC, {1'b1, c[1], 3'h0, c[0], 2'b00});
      apb(1, A_AX, {3'h0, c[0], 4'h0});
      apb(1, A_AB, {2'b00, c[1:0], 4'h0});
      // Steering outputs follow the register one edge after the write lands
      wait_n(1);
      check(pos_select, c[1:0]);
      check(pos_connect, c != 3);
      check(neg_select, c[1:0]);
      check(cmp_power_down, 1);
      check(cmp_capture_select, c[0]);
    end
    apb(1, A_SC, 8'h00);
    wait_n(1);
    check(cmp_power_down, 0);
    cmp_raw <= 1;
    wait_n(8);
    rd(A_SC, 0, 8'h30);
    apb(1, A_SC, 8'h10);
    rd(A_SC, 0, 8'h20);
    foreach (modes[i]) begin
      m = modes[i];
      apb(1, A_SC, {4'h1, 2'b00, m});
      cmp_raw <= 0;
      wait_n(8);
      rd(A_SC, 0, {3'b000, m == MODE_BOTH || m == MODE_FALL, 2'b00, m});
      apb(1, A_SC, {4'h1, 2'b00, m});
      cmp_raw <= 1;
      wait_n(8);
      rd(A_SC, 0, {3'b001, m == MODE_BOTH || m == MODE_RISE, 2'b00, m});
    end
    apb(1, A_SC, 8'h18);
    global_irq_enable <= 1;
    cmp_raw <= 0;
    wait_n(8);
    check(irq, 1);
    global_irq_enable <= 0;
    wait_n(2);
    check(irq, 0);
    global_irq_enable <= 1;
    wait_n(2);
    check(irq, 1);
    irq_ack <= 1;
    @(posedge pclk);
    irq_ack <= 0;
    wait_n(2);
    check(irq, 0);
    cmp_raw <= 1;
    wait_n(8);
    apb(1, A_SC, 8'h00);
    wait_n(2);
    check(irq, 0);
    // Reserved mode keeps the flag quiet while the filter is exercised
    apb(1, A_SC, 8'h11);
    for (int w = 1; w < 4; w++) begin
      apb(1, A_AX, {4'h1, 2'b11, w[1:0]});
      wk = 0;
      cmp_raw <= 0;
      wait_n(w * STEP - 2);
      cmp_raw <= 1;
      wait_n(8);
      check(wk, 0);
      rd(A_SC, 0, 8'h21);
      cmp_raw <= 0;
      wait_n(w * STEP + 8);
      rd(A_SC, 0, 8'h01);
      check(wk, 1);
      cmp_raw <= 1;
      wait_n(w * STEP + 8);
    end
    apb(1, A_AX, 8'h03);
    wk = 0;
    cmp_raw <= 0;
    wait_n(6);
    rd(A_SC, 0, 8'h01);
    check(wk, 0);
    cmp_raw <= 1;
    wait_n(6);
    apb(1, A_AB, 8'h00);
    cmp0_result <= 1;
    wait_n(6);
    check(adc_trigger, 1);
    cmp0_result <= 0;
    wait_n(6);
    check(adc_trigger, 0);
    apb(1, A_AB, 8'h08);
    wait_n(2);
    check(adc_trigger, 1);
    check(cmp_pin_out, 1);
    check(expq.size(), 0);
    end_of_test();
  end
endmodule

bind cmpo_control cmpo_control_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .global_irq_enable, .irq,
  .cmp_power_down, .pos_connect, .pos_select, .neg_select);
